// ===== design/otr_pkg.sv
// Constants, register map and curve tables of the overcurrent trip block
package otr_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 32'h0000_000a;
  localparam int TICK_PERIOD_NS = 32'h000f_4240;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 24;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int NPH = 3;
  localparam int MODE_W = 4;
  localparam int CUR_W = 16;
  localparam int DCUR_W = 32;
  localparam int GS_W = 12;
  localparam int TMS_W = 11;
  localparam int MS_W = 16;
  localparam int ACC_W = 24;
  localparam int NUM_W = 32;
  localparam int DEN_W = 25;
  localparam int LOG_W = 12;
  localparam int LOG_FRAC = 8;
  localparam int CMP_W = 68;
  localparam int EVT_W = 8;
  localparam int AW = 8;
  localparam int DW = 32;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [AW-1:0] ADDR_MODE = 8'h00;
  localparam logic [AW-1:0] ADDR_START = 8'h04;
  localparam logic [AW-1:0] ADDR_TMS = 8'h08;
  localparam logic [AW-1:0] ADDR_MIN = 8'h0c;
  localparam logic [AW-1:0] ADDR_DT = 8'h10;
  localparam logic [AW-1:0] ADDR_RST = 8'h14;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h18;
  localparam logic [AW-1:0] ADDR_IRQ_STAT = 8'h1c;
  localparam logic [AW-1:0] ADDR_IRQ_MASK = 8'h20;

  // ---------------------------------------------------------------
  // Setting ranges and reset values
  // ---------------------------------------------------------------
  localparam logic [MS_W-1:0] START_LO = 16'h000a;
  localparam logic [MS_W-1:0] START_HI = 16'h0bb8;
  localparam logic [MS_W-1:0] START_RST = 16'h00c8;
  localparam logic [MS_W-1:0] TMS_LO = 16'h0005;
  localparam logic [MS_W-1:0] TMS_HI = 16'h05dc;
  localparam logic [MS_W-1:0] TMS_RST = 16'h0064;
  localparam logic [MS_W-1:0] DLY_LO = 16'h0028;
  localparam logic [MS_W-1:0] RDLY_LO = 16'h003c;
  localparam logic [MS_W-1:0] DLY_HI = 16'hea60;
  localparam logic [MS_W-1:0] DLY_RST = 16'h0064;

  // ---------------------------------------------------------------
  // Modes, phase states, curve shapes
  // ---------------------------------------------------------------
  typedef enum logic [MODE_W-1:0] {
    MODE_OFF = 4'h0, MODE_DT = 4'h1,
    MODE_IEC_INV = 4'h2, MODE_IEC_VINV = 4'h3, MODE_IEC_EINV = 4'h4, MODE_IEC_LINV = 4'h5,
    MODE_ANSI_INV = 4'h6, MODE_ANSI_MINV = 4'h7, MODE_ANSI_VINV = 4'h8,
    MODE_ANSI_EINV = 4'h9, MODE_ANSI_LINV = 4'ha, MODE_ANSI_LVINV = 4'hb,
    MODE_ANSI_LEINV = 4'hc
  } otr_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_TRIP = 2'b11, ST_RESET = 2'b10
  } otr_state_t;

  localparam logic [1:0] ALPHA_P02 = 2'h0;
  localparam logic [1:0] ALPHA_ONE = 2'h1;
  localparam logic [1:0] ALPHA_TWO = 2'h2;

  // ---------------------------------------------------------------
  // Curve constants; k, c and kr in 0.1 ms, TMS in hundredths
  // ---------------------------------------------------------------
  localparam int NCURVE = 11;
  localparam logic [20:0] CURVE_K [0:NCURVE-1] = '{
    21'h578, 21'h2_0f58, 21'hc_3500, 21'h12_4f80, 21'h56, 21'h203,
    21'h2_fe04, 21'h4_4d90, 21'h35c, 21'h4_5b3c, 21'h9_c6bc};
  localparam logic [13:0] CURVE_C [0:NCURVE-1] = '{
    14'h0, 14'h0, 14'h0, 14'h0, 14'hb9, 14'h474,
    14'h132e, 14'h4c1, 14'h73a, 14'h1bd0, 14'h9c4};
  localparam logic [20:0] CURVE_KR [0:NCURVE-1] = '{
    21'h0, 21'h0, 21'h0, 21'h0, 21'h11f8, 21'hbd74,
    21'h3_4bc0, 21'h4_70b8, 21'hb3b0, 21'h2_0dc8, 21'h4_93e0};
  localparam logic [1:0] CURVE_ALPHA [0:NCURVE-1] = '{
    ALPHA_P02, ALPHA_ONE, ALPHA_TWO, ALPHA_ONE, ALPHA_P02, ALPHA_P02,
    ALPHA_TWO, ALPHA_TWO, ALPHA_P02, ALPHA_TWO, ALPHA_TWO};

  // Scaling of time and ratio terms
  localparam logic [9:0] MS_TO_US = 10'h3e8;
  localparam logic [9:0] LN_SCALE = 10'h38c;
  localparam logic [DEN_W-1:0] LOG_ONE = 25'h100_0000;
  localparam logic [4:0] SAT_RATIO = 5'h14;

endpackage

// ===== design/otr_tick.sv
// Processing tick divider of the overcurrent trip block
`timescale 1ns/1ps
`default_nettype none
module otr_tick #(
  parameter int TICK_CYCLES = otr_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // One-cycle tick
  output logic tick_o
);
  import otr_pkg::*;

  logic [TICK_CNT_W-1:0] cnt_ff;
  logic tick_ff;

  // -------------------------------------------------------------
  // Free-running divider, one pulse per processing period
  // -------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (cnt_ff == TICK_CNT_W'(TICK_CYCLES - 1)) begin
      cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= TICK_CNT_W'(cnt_ff + 1'b1);
      tick_ff <= 1'b0;
    end
  end

  assign tick_o = tick_ff;
endmodule
`default_nettype wire

// ===== design/otr_curve.sv
// Ratio term of the inverse curves as numerator over denominator
`timescale 1ns/1ps
`default_nettype none
module otr_curve (
  // Measurement and threshold
  input wire logic [otr_pkg::CUR_W-1:0] g_i,
  input wire logic [otr_pkg::GS_W-1:0] gs_i,
  // Curve exponent class
  input wire logic [1:0] alpha_i,
  // (G/Gs)^alpha - 1 as num_o / den_o
  output logic [otr_pkg::NUM_W-1:0] num_o,
  output logic [otr_pkg::DEN_W-1:0] den_o
);
  import otr_pkg::*;

  // Base-two log, integer part above LOG_FRAC fraction bits
  function automatic logic [LOG_W-1:0] log2_fx(input logic [CUR_W-1:0] x);
    logic [CUR_W-1:0] sh;
    logic [3:0] p;
    sh = x;
    p = 4'h0;
    for (int i = 0; i < CUR_W; i++) begin
      if (x[i]) begin
        p = 4'(i);
        sh = x << (CUR_W - 1 - i);
      end
    end
    return {p, sh[CUR_W-2 -: LOG_FRAC]};
  endfunction

  logic [CUR_W-1:0] gd;
  logic [CUR_W-1:0] gc;
  logic [CUR_W-1:0] gs;
  logic [DCUR_W-1:0] g2;
  logic [DCUR_W-1:0] gs2;
  logic [LOG_W-1:0] dlog;

  // -------------------------------------------------------------
  // Saturate at 20 x threshold, then form the ratio term
  // -------------------------------------------------------------
  always_comb begin
    gs = CUR_W'(gs_i);
    gd = gs * CUR_W'(SAT_RATIO);
    gc = (g_i > gd) ? gd : g_i;
    g2 = DCUR_W'(gc) * DCUR_W'(gc);
    gs2 = DCUR_W'(gs) * DCUR_W'(gs);
    dlog = log2_fx(gc) - log2_fx(gs);
    num_o = '0;
    den_o = LOG_ONE;
    if (gc > gs) begin
      case (alpha_i)
        // Small exponent: r^a - 1 taken as a*ln(r), under 3% off at 20x
        ALPHA_P02: begin
          num_o = NUM_W'(dlog) * NUM_W'(LN_SCALE);
          den_o = LOG_ONE;
        end
        ALPHA_ONE: begin
          num_o = NUM_W'(gc - gs);
          den_o = DEN_W'(gs);
        end
        default: begin
          num_o = g2 - gs2;
          den_o = DEN_W'(gs2);
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== design/otr_top.sv
// Three-phase time-overcurrent trip element with APB settings
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module otr_top #(
  parameter int TICK_CYCLES = otr_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [otr_pkg::AW-1:0] paddr_i,
  input wire logic [otr_pkg::DW-1:0] pwdata_i,
  output logic [otr_pkg::DW-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Measurements, percent of nominal
  input wire logic [otr_pkg::CUR_W-1:0] phase1_fundamental_rms_i,
  input wire logic [otr_pkg::CUR_W-1:0] phase2_fundamental_rms_i,
  input wire logic [otr_pkg::CUR_W-1:0] phase3_fundamental_rms_i,
  // Block input
  input wire logic element_inhibit_i,
  // Status outputs
  output logic phase1_pickup_o,
  output logic phase2_pickup_o,
  output logic phase3_pickup_o,
  output logic phase1_trip_o,
  output logic phase2_trip_o,
  output logic phase3_trip_o,
  output logic any_phase_pickup_o,
  output logic any_phase_trip_o,
  // Interrupt
  output logic irq_o
);
  import otr_pkg::*;

  // -------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------
  logic [MODE_W-1:0] mode_ff;
  logic [GS_W-1:0] start_ff;
  logic [TMS_W-1:0] tms_ff;
  logic [MS_W-1:0] min_ff;
  logic [MS_W-1:0] dt_ff;
  logic [MS_W-1:0] rst_ff;
  logic [EVT_W-1:0] irq_stat_ff;
  logic [EVT_W-1:0] irq_mask_ff;
  logic [EVT_W-1:0] nxt_irq_stat;
  logic [EVT_W-1:0] out_ff;
  logic [EVT_W-1:0] nxt_out;
  logic [NPH-1:0] nxt_pick;
  logic [NPH-1:0] nxt_trip;
  logic [DW-1:0] prdata_ff;
  logic [DW-1:0] rdata;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  logic addr_hit;
  logic acc_first;
  logic wr_en;
  logic tick;
  logic enabled;
  logic mode_dt;
  logic mode_iec;
  logic [3:0] cidx;
  logic [1:0] alpha;
  logic [31:0] tms_k;
  logic [31:0] tms_kr;
  logic [24:0] tms_c;
  logic [CUR_W-1:0] meas [NPH];
  logic [DCUR_W-1:0] gs2;

  // Write value held inside a setting range
  function automatic logic [MS_W-1:0] clamp(input logic [DW-1:0] v,
                                            input logic [MS_W-1:0] lo,
                                            input logic [MS_W-1:0] hi);
    logic [MS_W-1:0] r;
    r = (v < DW'(lo)) ? lo : ((v > DW'(hi)) ? hi : MS_W'(v));
    return r;
  endfunction

  // -------------------------------------------------------------
  // Processing tick
  // -------------------------------------------------------------
  otr_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .tick_o(tick)
  );

  // -------------------------------------------------------------
  // APB slave: one wait state, unmapped address gives PSLVERR
  // -------------------------------------------------------------
  assign acc_first = psel_i & penable_i & ~pready_ff;
  assign wr_en = psel_i & penable_i & pready_ff & pwrite_i & ~pslverr_ff;

  // Address decode and read mux
  always_comb begin
    addr_hit = 1'b1;
    rdata = '0;
    case (paddr_i)
      ADDR_MODE: rdata = DW'(mode_ff);
      ADDR_START: rdata = DW'(start_ff);
      ADDR_TMS: rdata = DW'(tms_ff);
      ADDR_MIN: rdata = DW'(min_ff);
      ADDR_DT: rdata = DW'(dt_ff);
      ADDR_RST: rdata = DW'(rst_ff);
      ADDR_STATUS: rdata = DW'({element_inhibit_i, enabled, out_ff});
      ADDR_IRQ_STAT: rdata = DW'(irq_stat_ff);
      ADDR_IRQ_MASK: rdata = DW'(irq_mask_ff);
      default: addr_hit = 1'b0;
    endcase
  end

  // Answer registers, loaded in the first access cycle
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= acc_first;
      pslverr_ff <= acc_first & ~addr_hit;
      if (acc_first) begin
        prdata_ff <= pwrite_i ? '0 : rdata;
      end
    end
  end

  // -------------------------------------------------------------
  // Settings; out-of-range writes are held at the range ends, unknown mode codes are ignored
  // -------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      mode_ff <= MODE_OFF;
      start_ff <= GS_W'(START_RST);
      tms_ff <= TMS_W'(TMS_RST);
      min_ff <= DLY_RST;
      dt_ff <= DLY_RST;
      rst_ff <= DLY_RST;
      irq_mask_ff <= '0;
    end else if (wr_en) begin
      case (paddr_i)
        ADDR_MODE: begin
          // Unknown codes are ignored so a bad write cannot arm the element
          if (pwdata_i <= DW'(MODE_ANSI_LEINV)) begin
            mode_ff <= MODE_W'(pwdata_i);
          end
        end
        ADDR_START: start_ff <= GS_W'(clamp(pwdata_i, START_LO, START_HI));
        ADDR_TMS: tms_ff <= TMS_W'(clamp(pwdata_i, TMS_LO, TMS_HI));
        ADDR_MIN: min_ff <= clamp(pwdata_i, DLY_LO, DLY_HI);
        ADDR_DT: dt_ff <= clamp(pwdata_i, DLY_LO, DLY_HI);
        ADDR_RST: rst_ff <= clamp(pwdata_i, RDLY_LO, DLY_HI);
        ADDR_IRQ_MASK: irq_mask_ff <= pwdata_i[EVT_W-1:0];
        default: mode_ff <= mode_ff;
      endcase
    end
  end

  // -------------------------------------------------------------
  // Mode decode and curve constants scaled by the multiplier
  // -------------------------------------------------------------
  always_comb begin
    enabled = (mode_ff != MODE_OFF) & ~element_inhibit_i;
    mode_dt = (mode_ff == MODE_DT);
    mode_iec = (mode_ff >= MODE_IEC_INV) & (mode_ff <= MODE_IEC_LINV);
    cidx = (mode_ff >= MODE_IEC_INV) ? 4'(mode_ff - MODE_IEC_INV) : 4'h0;
    alpha = CURVE_ALPHA[cidx];
    tms_k = 32'(tms_ff) * 32'(CURVE_K[cidx]);
    tms_c = 25'(tms_ff) * 25'(CURVE_C[cidx]);
    tms_kr = 32'(tms_ff) * 32'(CURVE_KR[cidx]);
    gs2 = DCUR_W'(start_ff) * DCUR_W'(start_ff);
  end

  assign meas[0] = phase1_fundamental_rms_i;
  assign meas[1] = phase2_fundamental_rms_i;
  assign meas[2] = phase3_fundamental_rms_i;

  // -------------------------------------------------------------
  // Per-phase timing
  // -------------------------------------------------------------
  for (genvar gi = 0; gi < NPH; gi++) begin : g_ph
    otr_state_t st_ff;
    otr_state_t nxt_st;
    logic [ACC_W-1:0] op_ff;
    logic [ACC_W-1:0] rs_ff;
    logic [ACC_W-1:0] nxt_op;
    logic [ACC_W-1:0] nxt_rs;
    logic [ACC_W-1:0] op_inc;
    logic [ACC_W-1:0] rs_inc;
    logic [NUM_W-1:0] num;
    logic [DEN_W-1:0] den;
    logic [DCUR_W-1:0] g2;
    logic [CMP_W-1:0] e_us;
    logic [CMP_W-1:0] r_us;
    logic pick;
    logic op_done;
    logic rs_done;

    otr_curve u_curve (
      .g_i(meas[gi]),
      .gs_i(start_ff),
      .alpha_i(alpha),
      .num_o(num),
      .den_o(den)
    );

    assign pick = meas[gi] > CUR_W'(start_ff);

    // Operate and reset conditions; cross-multiplied to avoid dividers
    always_comb begin
      op_inc = (&op_ff) ? op_ff : ACC_W'(op_ff + 1'b1);
      rs_inc = (&rs_ff) ? rs_ff : ACC_W'(rs_ff + 1'b1);
      g2 = DCUR_W'(meas[gi]) * DCUR_W'(meas[gi]);
      e_us = CMP_W'(op_inc) * CMP_W'(MS_TO_US);
      r_us = CMP_W'(rs_inc) * CMP_W'(MS_TO_US);
      if (mode_dt) begin
        op_done = (op_inc >= ACC_W'(dt_ff));
      end else begin
        op_done = (e_us > CMP_W'(tms_c)) & (op_inc >= ACC_W'(min_ff)) &
                  ((e_us - CMP_W'(tms_c)) * CMP_W'(num) >=
                   CMP_W'(tms_k) * CMP_W'(den));
      end
      if (mode_iec) begin
        rs_done = (rs_inc >= ACC_W'(rst_ff));
      end else begin
        rs_done = (meas[gi] >= CUR_W'(start_ff)) |
                  (r_us * CMP_W'(gs2 - g2) >= CMP_W'(tms_kr) * CMP_W'(gs2));
      end
    end

    // Phase state machine, stepped once per tick
    always_comb begin
      nxt_st = st_ff;
      nxt_op = op_ff;
      nxt_rs = rs_ff;
      if (!enabled) begin
        nxt_st = ST_IDLE;
        nxt_op = '0;
        nxt_rs = '0;
      end else if (tick) begin
        case (st_ff)
          ST_IDLE: begin
            if (pick) begin
              nxt_st = ST_RUN;
            end
          end
          ST_RUN, ST_TRIP: begin
            if (!pick) begin
              nxt_st = mode_dt ? ST_IDLE : ST_RESET;
              nxt_op = mode_dt ? '0 : op_ff;
              nxt_rs = '0;
            end else begin
              nxt_op = op_inc;
              nxt_st = op_done ? ST_TRIP : st_ff;
            end
          end
          ST_RESET: begin
            // Accumulated time survives a short dip below threshold
            if (pick) begin
              nxt_st = ST_RUN;
              nxt_rs = '0;
            end else if (rs_done) begin
              nxt_st = ST_IDLE;
              nxt_op = '0;
              nxt_rs = '0;
            end else begin
              nxt_rs = rs_inc;
            end
          end
          default: nxt_st = ST_IDLE;
        endcase
      end
    end

    // Phase state registers
    always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
        st_ff <= ST_IDLE;
        op_ff <= '0;
        rs_ff <= '0;
      end else begin
        st_ff <= nxt_st;
        op_ff <= nxt_op;
        rs_ff <= nxt_rs;
      end
    end

    assign nxt_pick[gi] = (nxt_st == ST_RUN) | (nxt_st == ST_TRIP);
    assign nxt_trip[gi] = (nxt_st == ST_TRIP);
  end

  // -------------------------------------------------------------
  // Output registers and general OR
  // -------------------------------------------------------------
  assign nxt_out = {|nxt_trip, |nxt_pick, nxt_trip, nxt_pick};

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      out_ff <= '0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  // -------------------------------------------------------------
  // Interrupts: any output edge sets a sticky bit; set beats clear
  // -------------------------------------------------------------
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_en && paddr_i == ADDR_IRQ_STAT) begin
      nxt_irq_stat = irq_stat_ff & ~pwdata_i[EVT_W-1:0];
    end
    nxt_irq_stat = nxt_irq_stat | (nxt_out ^ out_ff);
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      irq_stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  // Port drive, all from flops
  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign phase1_pickup_o = out_ff[0];
  assign phase2_pickup_o = out_ff[1];
  assign phase3_pickup_o = out_ff[2];
  assign phase1_trip_o = out_ff[3];
  assign phase2_trip_o = out_ff[4];
  assign phase3_trip_o = out_ff[5];
  assign any_phase_pickup_o = out_ff[6];
  assign any_phase_trip_o = out_ff[7];
  assign irq_o = irq_ff;
endmodule
`default_nettype wire

// ===== testbench/otr_meas_model.sv
// Phase current source standing in for the measurement chain
`timescale 1ns/1ps
`default_nettype none
module otr_meas_model (
  // Clock
  input wire logic clock_i,
  // Requested magnitudes, phase 1 in the low bits
  input wire logic [47:0] level_i,
  // Fundamental RMS magnitudes, one per phase
  output logic [15:0] ph1_o = 16'h0000,
  output logic [15:0] ph2_o = 16'h0000,
  output logic [15:0] ph3_o = 16'h0000
);
  // One magnitude per phase, refreshed each clock like a settled filter
  always_ff @(posedge clock_i) begin
    ph1_o <= level_i[15:0];
    ph2_o <= level_i[31:16];
    ph3_o <= level_i[47:32];
  end
endmodule
`default_nettype wire

// ===== testbench/otr_properties.sv
// Checker of the overcurrent trip block port behaviour
`timescale 1ns/1ps
`default_nettype none
module otr_chk #(
  parameter int TICK_CYCLES = 10
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Bus handshake
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Measurement and block input
  input wire logic [15:0] phase1_fundamental_rms_i,
  input wire logic element_inhibit_i,
  // Status outputs
  input wire logic phase1_pickup_o,
  input wire logic phase2_pickup_o,
  input wire logic phase3_pickup_o,
  input wire logic phase1_trip_o,
  input wire logic phase2_trip_o,
  input wire logic phase3_trip_o,
  input wire logic any_phase_pickup_o,
  input wire logic any_phase_trip_o
);
  // Range bound only suits short ticks; long ticks need a counter
  localparam int TW = TICK_CYCLES + 2;
  wire [2:0] pk = {phase3_pickup_o, phase2_pickup_o, phase1_pickup_o};
  wire [2:0] tr = {phase3_trip_o, phase2_trip_o, phase1_trip_o};
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence s_setup; psel_i && !penable_i; endsequence
  sequence s_enter; psel_i && penable_i; endsequence
  property p_answer; s_setup ##1 s_enter |=> pready_o; endproperty
  a_answer: assert property (p_answer) else $error("no bus answer");
  property p_pulse; pready_o |=> !pready_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_err; pslverr_o |-> pready_o; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_any_pk; any_phase_pickup_o == (|pk); endproperty
  a_any_pk: assert property (p_any_pk) else $error("general pickup");
  property p_any_tr; any_phase_trip_o == (|tr); endproperty
  a_any_tr: assert property (p_any_tr) else $error("general trip");
  property p_inh; element_inhibit_i |=> (pk == 3'h0) && (tr == 3'h0); endproperty
  a_inh: assert property (p_inh) else $error("active while inhibited");
  property p_tr_pk; (tr & ~pk) == 3'h0; endproperty
  a_tr_pk: assert property (p_tr_pk) else $error("trip without pickup");
  property p_tr_rise; $rose(phase1_trip_o) |-> $past(phase1_pickup_o); endproperty
  a_tr_rise: assert property (p_tr_rise) else $error("trip with no run");
  property p_low; (phase1_fundamental_rms_i == 16'h0000) [*8] |-> ##[0:TW] !phase1_pickup_o;
  endproperty
  a_low: assert property (p_low) else $error("pickup at zero current");
endmodule
bind otr_top otr_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
  .clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .element_inhibit_i(element_inhibit_i),
  .phase1_fundamental_rms_i(phase1_fundamental_rms_i),
  .phase1_pickup_o(phase1_pickup_o), .phase2_pickup_o(phase2_pickup_o),
  .phase3_pickup_o(phase3_pickup_o), .phase1_trip_o(phase1_trip_o),
  .phase2_trip_o(phase2_trip_o), .phase3_trip_o(phase3_trip_o),
  .any_phase_pickup_o(any_phase_pickup_o), .any_phase_trip_o(any_phase_trip_o));
`default_nettype wire

// ===== testbench/three_phase_overcurrent_trip_tb.sv
// Self-checking bench of the three-phase overcurrent trip block
`timescale 1ns/1ps
`default_nettype none
module three_phase_overcurrent_trip_tb;
  import otr_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int TC = 10; // Short tick keeps trip times to a few thousand clocks
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, inh = 1'b0, err;
  logic [7:0] pad = 8'h00;
  logic [31:0] pwd = 32'h0000_0000, q;
  logic [47:0] lvl = 48'h0000_0000_0000;
  wire [31:0] prd;
  wire prdy, perr, irq;
  wire [15:0] c1, c2, c3;
  wire [7:0] o;
  int n_errors = 0, n_tests = 0, n;
  logic [7:0] ca [6] = '{ADDR_START, ADDR_START, ADDR_TMS, ADDR_MIN, ADDR_DT, ADDR_RST};
  logic [31:0] cw [6] = '{32'h0000_0005, 32'h0000_0fa0, 32'h0000_07d0, 32'h0000_0000,
    32'h0001_1170, 32'h0000_0001};
  logic [15:0] ce [6] = '{START_LO, START_HI, TMS_HI, DLY_LO, DLY_HI, RDLY_LO};
  always #5 clock_i = ~clock_i;
  otr_meas_model meas (.clock_i(clock_i), .level_i(lvl), .ph1_o(c1), .ph2_o(c2), .ph3_o(c3));
  otr_top #(.TICK_CYCLES(TC)) uut (
    .clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pad), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .phase1_fundamental_rms_i(c1), .phase2_fundamental_rms_i(c2),
    .phase3_fundamental_rms_i(c3), .element_inhibit_i(inh),
    .phase1_pickup_o(o[0]), .phase2_pickup_o(o[1]), .phase3_pickup_o(o[2]),
    .phase1_trip_o(o[3]), .phase2_trip_o(o[4]), .phase3_trip_o(o[5]),
    .any_phase_pickup_o(o[6]), .any_phase_trip_o(o[7]), .irq_o(irq));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d of %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Bus cycle held until ready; a stuck slave ends the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pad <= a;
    pwd <= d;
    @(posedge clock_i);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (prdy !== 1'b1 && n < 9);
    if (prdy !== 1'b1) begin
      chk(0, 1);
      end_sim();
    end
    q = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic x);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, e);
    chk(err, x);
  endtask
  // Bounded wait for one output bit; n ends as the cycles spent
  task automatic wt(input int b, input logic v, input int lim);
    n = 0;
    while (o[b] !== v && n < lim) begin
      @(posedge clock_i);
      n++;
    end
    if (o[b] !== v) begin
      chk(0, 1);
      end_sim();
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    chk(o, 0);
    rdc(ADDR_MODE, 0, 0);
    rdc(ADDR_START, START_RST, 0);
    rdc(ADDR_TMS, TMS_RST, 0);
    rdc(ADDR_MIN, DLY_RST, 0);
    rdc(ADDR_DT, DLY_RST, 0);
    rdc(ADDR_RST, DLY_RST, 0);
    rdc(8'h40, 0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ca[i], cw[i]);
      rdc(ca[i], ce[i], 0);
    end
    apb(1'b1, ADDR_START, 32'h0000_00c8);
    apb(1'b1, ADDR_DT, 32'h0000_0028);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
    lvl <= 48'h0000_0000_012c;
    repeat (3 * TC) @(posedge clock_i);
    chk(o, 0);
    apb(1'b1, ADDR_MODE, MODE_DT);
    for (int p = 0; p < 3; p++) begin
      lvl <= 48'h0000_0000_012c << (16 * p);
      wt(p, 1'b1, 3 * TC);
      wt(p + 3, 1'b1, 42 * TC);
      chk(32'(n >= 39 * TC), 1);
      chk(o, 8'hc0 | (8'h09 << p));
      lvl <= 48'h0000_0000_0000;
      wt(p, 1'b0, 3 * TC);
      chk(o, 0);
    end
    // Current equal to the threshold must not start
    lvl <= 48'h0000_0000_00c8;
    repeat (3 * TC) @(posedge clock_i);
    chk(o, 0);
    chk(irq, 1);
    rdc(ADDR_IRQ_STAT, 32'h0000_00ff, 0);
    apb(1'b1, ADDR_IRQ_STAT, 32'h0000_00ff);
    rdc(ADDR_IRQ_STAT, 0, 0);
    chk(irq, 0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0000);
    // Inhibit mid-timing: the delay must restart from zero
    lvl <= 48'h0000_012c_0000;
    wt(1, 1'b1, 3 * TC);
    repeat (20 * TC) @(posedge clock_i);
    inh <= 1'b1;
    repeat (2) @(posedge clock_i);
    chk(o, 0);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(q[9], 1);
    chk(irq, 0);
    inh <= 1'b0;
    wt(1, 1'b1, 3 * TC);
    wt(4, 1'b1, 42 * TC);
    chk(32'(n >= 39 * TC), 1);
    lvl <= 48'h0000_0000_0000;
    wt(1, 1'b0, 3 * TC);
    // Inverse curve, ratio 3 at multiplier 0.05 gives about 338 ticks
    apb(1'b1, ADDR_TMS, 32'h0000_0005);
    apb(1'b1, ADDR_MODE, MODE_IEC_VINV);
    apb(1'b1, ADDR_MODE, 32'h0000_000f);
    rdc(ADDR_MODE, MODE_IEC_VINV, 0);
    lvl <= 48'h0258_0000_0000;
    wt(2, 1'b1, 3 * TC);
    wt(5, 1'b1, 360 * TC);
    chk(32'(n >= 320 * TC), 1);
    // Short dip keeps the accumulated time; a long one resets it
    lvl <= 48'h0000_0000_0000;
    wt(5, 1'b0, 3 * TC);
    repeat (20 * TC) @(posedge clock_i);
    lvl <= 48'h0258_0000_0000;
    wt(5, 1'b1, 3 * TC);
    lvl <= 48'h0000_0000_0000;
    wt(5, 1'b0, 3 * TC);
    repeat (70 * TC) @(posedge clock_i);
    lvl <= 48'h0258_0000_0000;
    wt(5, 1'b1, 360 * TC);
    chk(32'(n >= 320 * TC), 1);
    // Saturation at 20x, then the minimum delay floor
    apb(1'b1, ADDR_TMS, 32'h0000_000a);
    lvl <= 48'h0000_0000_ffff;
    wt(3, 1'b1, 80 * TC);
    chk(32'(n >= 65 * TC), 1);
    lvl <= 48'h0000_0000_0000;
    wt(3, 1'b0, 3 * TC);
    apb(1'b1, ADDR_MIN, 32'h0000_0064);
    repeat (70 * TC) @(posedge clock_i);
    lvl <= 48'h0000_0000_ffff;
    wt(3, 1'b1, 110 * TC);
    chk(32'(n >= 95 * TC), 1);
    end_sim();
  end
endmodule
`default_nettype wire
